/* File: inc/usb_clock_bringup_pkg.sv */
`default_nettype none
package usb_clock_bringup_pkg;

  localparam int unsigned CLK_HZ            = 25_000_000;
  localparam int unsigned CLK_MHZ           = CLK_HZ / 1_000_000;
  localparam int unsigned SETTLE_US         = 2000;
  localparam int unsigned RECHECK_US        = 100;
  localparam int unsigned SETTLE_CYCLES_DFLT = SETTLE_US * CLK_MHZ;
  localparam logic [15:0] RECHECK_CYCLES    = 16'(RECHECK_US * CLK_MHZ);
  localparam logic [15:0] USB_EN_GAP_CYCLES = 16'h0004;
  localparam logic [8:0]  CAP_EXTRA_TENTHS  = 9'h00a;

  localparam logic [7:0]  CLOCK_CTRL_RST    = 8'h80;
  localparam logic [7:0]  SYNTH_CTRL_RST    = 8'h60;
  localparam logic [7:0]  TIMER_MODE_RST    = 8'h00;
  localparam logic [7:0]  USB_CTRL_RST      = 8'h00;

  localparam int unsigned STOP_RELEASE_POS  = 7;
  localparam int unsigned USB_CLK_EN_POS    = 6;
  localparam int unsigned SYNTH_EN_POS      = 0;
  localparam int unsigned SYNTH_RATIO_LSB   = 5;
  localparam logic [1:0]  SYNTH_RATIO_LOCKED = 2'b10;
  localparam int unsigned TIMER_KEEP_POS    = 4;
  localparam int unsigned USB_EN_POS        = 7;
  localparam int unsigned LINE_SUPPLY_POS   = 4;
  localparam int unsigned LINE_CURRENT_POS  = 3;

  typedef enum logic [3:0] {
    S_IDLE,
    S_SETTLE,
    S_POLL,
    S_RECHECK,
    S_SUPPLY,
    S_CHARGE,
    S_CLKEN,
    S_DONE
  } seq_state_e;

endpackage
`default_nettype wire

/* File: src/wait_counter.sv */
`timescale 1ns/1ns
`default_nettype none
// Down counter; done rises load_value cycles after the load edge and holds.
module wait_counter (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  output var  logic        done
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_done;

  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (load) begin
      next_count = load_value;
    end else begin
      next_done = (count <= 16'h0001);
      if (count != 16'h0000) begin
        next_count = count - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end

endmodule // wait_counter
`default_nettype wire

/* File: src/usb_clock_bringup_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module usb_clock_bringup_sequencer
  import usb_clock_bringup_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYCLES_DFLT
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       seq_start,
  input  wire logic       use_dcdc,
  input  wire logic [7:0] cap_tenths_uf,
  input  wire logic       synth_lock,
  input  wire logic       stop_instruction,
  input  wire logic       clock_control_wr,
  input  wire logic [7:0] clock_control_wdata,
  input  wire logic       synth_control_wr,
  input  wire logic [7:0] synth_control_wdata,
  input  wire logic       timer_mode_wr,
  input  wire logic [7:0] timer_mode_wdata,
  input  wire logic       usb_control_wr,
  input  wire logic [7:0] usb_control_wdata,
  output var  logic [7:0] clock_control_register,
  output var  logic [7:0] synth_control_register,
  output var  logic [7:0] timer_mode_register,
  output var  logic [7:0] usb_control_register,
  output var  logic       synth_lock_status,
  output var  logic       seq_busy,
  output var  logic       seq_done
);

  seq_state_e  state;
  seq_state_e  next_state;
  logic [7:0]  next_clock_control;
  logic [7:0]  next_synth_control;
  logic [7:0]  next_timer_mode;
  logic [7:0]  next_usb_control;
  logic        next_lock_status;
  logic        next_seq_busy;
  logic        next_seq_done;
  logic [8:0]  charge_left;
  logic [8:0]  next_charge_left;
  logic        timer_load;
  logic [15:0] timer_value;
  logic        timer_done;

  // Every microsecond wait is a count of ref_clk cycles.
  wait_counter u_wait (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .load       (timer_load),
    .load_value (timer_value),
    .done       (timer_done)
  );

  always_comb begin
    next_state         = state;
    next_clock_control = clock_control_register;
    next_synth_control = synth_control_register;
    next_timer_mode    = timer_mode_register;
    next_usb_control   = usb_control_register;
    next_charge_left   = charge_left;
    timer_load         = 1'b0;
    timer_value        = 16'h0000;

    if (clock_control_wr) begin
      next_clock_control = clock_control_wdata;
    end
    if (synth_control_wr) begin
      next_synth_control = synth_control_wdata;
    end
    if (timer_mode_wr) begin
      next_timer_mode = timer_mode_wdata;
    end
    if (usb_control_wr) begin
      next_usb_control = usb_control_wdata;
    end

    // The lock bit only reports lock while the synthesizer is enabled.
    next_lock_status = synth_lock & synth_control_register[SYNTH_EN_POS];

    case (state)
      S_IDLE: begin
        if (seq_start) begin
          next_synth_control[SYNTH_EN_POS] = 1'b1;
          timer_load  = 1'b1;
          timer_value = 16'(SETTLE_CYCLES);
          next_state  = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (timer_done) begin
          next_state = S_POLL;
        end
      end
      S_POLL: begin
        if (synth_lock_status) begin
          next_synth_control[SYNTH_RATIO_LSB +: 2] = SYNTH_RATIO_LOCKED;
          next_state = S_SUPPLY;
        end else begin
          timer_load  = 1'b1;
          timer_value = RECHECK_CYCLES;
          next_state  = S_RECHECK;
        end
      end
      S_RECHECK: begin
        if (timer_done) begin
          next_state = S_POLL;
        end
      end
      S_SUPPLY: begin
        // Reached only after the 2 ms settle, so the supply may come up now.
        if (use_dcdc) begin
          next_usb_control[LINE_SUPPLY_POS]  = 1'b1;
          next_usb_control[LINE_CURRENT_POS] = 1'b0;
        end
        next_charge_left = {1'b0, cap_tenths_uf} + CAP_EXTRA_TENTHS;
        timer_load  = 1'b1;
        timer_value = RECHECK_CYCLES;
        next_state  = S_CHARGE;
      end
      S_CHARGE: begin
        if (timer_done) begin
          if (charge_left <= 9'h001) begin
            next_clock_control[USB_CLK_EN_POS] = 1'b1;
            timer_load  = 1'b1;
            timer_value = USB_EN_GAP_CYCLES;
            next_state  = S_CLKEN;
          end else begin
            next_charge_left = charge_left - 9'h001;
            timer_load  = 1'b1;
            timer_value = RECHECK_CYCLES;
          end
        end
      end
      S_CLKEN: begin
        if (timer_done) begin
          next_usb_control[USB_EN_POS] = 1'b1;
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        next_state = S_DONE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase

    // Stop overrides a timer mode write and the stop release bit of a clock control write in the same cycle.
    if (stop_instruction) begin
      next_clock_control[STOP_RELEASE_POS] = 1'b0;
      next_timer_mode = timer_mode_register & (8'h01 << TIMER_KEEP_POS);
    end

    next_seq_busy = (next_state != S_IDLE) && (next_state != S_DONE);
    next_seq_done = (next_state == S_DONE);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state                  <= S_IDLE;
      clock_control_register <= CLOCK_CTRL_RST;
      synth_control_register <= SYNTH_CTRL_RST;
      timer_mode_register    <= TIMER_MODE_RST;
      usb_control_register   <= USB_CTRL_RST;
      synth_lock_status      <= 1'b0;
      charge_left            <= 9'h000;
      seq_busy               <= 1'b0;
      seq_done               <= 1'b0;
    end else begin
      state                  <= next_state;
      clock_control_register <= next_clock_control;
      synth_control_register <= next_synth_control;
      timer_mode_register    <= next_timer_mode;
      usb_control_register   <= next_usb_control;
      synth_lock_status      <= next_lock_status;
      charge_left            <= next_charge_left;
      seq_busy               <= next_seq_busy;
      seq_done               <= next_seq_done;
    end
  end

  property p_stop_clears_release;
    @(posedge ref_clk) disable iff (rst)
      stop_instruction |=> !clock_control_register[STOP_RELEASE_POS];
  endproperty
  a_stop_clears_release: assert property (p_stop_clears_release)
    else $error("stop did not clear the stop release bit");

  property p_release_by_write;
    @(posedge ref_clk) disable iff (rst)
      (clock_control_wr && clock_control_wdata[STOP_RELEASE_POS] && !stop_instruction)
      |=> clock_control_register[STOP_RELEASE_POS];
  endproperty
  a_release_by_write: assert property (p_release_by_write)
    else $error("writing one did not set the stop release bit");

  property p_stop_timer_mode;
    @(posedge ref_clk) disable iff (rst)
      stop_instruction |=> ((timer_mode_register & 8'hef) == 8'h00)
        && (timer_mode_register[TIMER_KEEP_POS] == $past(timer_mode_register[TIMER_KEEP_POS]));
  endproperty
  a_stop_timer_mode: assert property (p_stop_timer_mode)
    else $error("stop left wrong timer mode bits");

  property p_lock_report;
    @(posedge ref_clk) disable iff (rst)
      (synth_lock && synth_control_register[SYNTH_EN_POS]) |=> synth_lock_status;
  endproperty
  a_lock_report: assert property (p_lock_report)
    else $error("lock was not reported");

  property p_recheck_spacing;
    @(posedge ref_clk) disable iff (rst)
      (state == S_POLL && !synth_lock_status) |=> (state == S_RECHECK) [*8];
  endproperty
  a_recheck_spacing: assert property (p_recheck_spacing)
    else $error("lock rechecked too early");

  property p_ratio_after_lock;
    @(posedge ref_clk) disable iff (rst)
      (state == S_POLL && synth_lock_status && !synth_control_wr && !stop_instruction)
      |=> synth_control_register[6:5] == 2'b10;
  endproperty
  a_ratio_after_lock: assert property (p_ratio_after_lock)
    else $error("ratio bits not set to 10 after lock");

  property p_usb_enable_gap;
    @(posedge ref_clk) disable iff (rst)
      (state == S_CLKEN && $past(state) != S_CLKEN) |-> !usb_control_register[USB_EN_POS] [*4];
  endproperty
  a_usb_enable_gap: assert property (p_usb_enable_gap)
    else $error("usb enabled too soon after usb clock");

endmodule // usb_clock_bringup_sequencer
`default_nettype wire

/* File: bench/tb_usb_clock_bringup_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_usb_clock_bringup_sequencer;
  import usb_clock_bringup_pkg::*;
  localparam int unsigned SETTLE = 20;
  typedef struct {int idx; logic [7:0] val;} note_s;
  logic       ref_clk = 1'b0, rst = 1'b1, seq_start = 1'b0, use_dcdc = 1'b1;
  logic [7:0] cap_tenths_uf = 8'h00;
  logic       synth_lock = 1'b0, stop_instruction = 1'b0;
  logic       clock_control_wr = 1'b0, synth_control_wr = 1'b0;
  logic       timer_mode_wr = 1'b0, usb_control_wr = 1'b0;
  logic [7:0] clock_control_wdata = 8'h00, synth_control_wdata = 8'h00;
  logic [7:0] timer_mode_wdata = 8'h00, usb_control_wdata = 8'h00;
  logic [7:0] clock_control_register, synth_control_register;
  logic [7:0] timer_mode_register, usb_control_register;
  logic       synth_lock_status, seq_busy, seq_done, timing_ok;
  note_s      notes[$];
  note_s      cur;
  event       sample_ev;
  int         bad_count = 0;
  int         checks_done = 0;
  int         n;
  logic [7:0] r;
  string      nm [8] = '{"clock_control", "synth_control", "timer_mode", "usb_control",
                         "lock_status", "busy", "done", "timing"};

  always #20 ref_clk = ~ref_clk;

  usb_clock_bringup_sequencer #(.SETTLE_CYCLES(SETTLE)) DUT (
    .ref_clk, .rst, .seq_start, .use_dcdc, .cap_tenths_uf, .synth_lock, .stop_instruction,
    .clock_control_wr, .clock_control_wdata, .synth_control_wr, .synth_control_wdata,
    .timer_mode_wr, .timer_mode_wdata, .usb_control_wr, .usb_control_wdata,
    .clock_control_register, .synth_control_register, .timer_mode_register,
    .usb_control_register, .synth_lock_status, .seq_busy, .seq_done
  );

  function automatic logic [7:0] seen(int i);
    case (i)
      0: return clock_control_register;
      1: return synth_control_register;
      2: return timer_mode_register;
      3: return usb_control_register;
      4: return {7'h00, synth_lock_status};
      5: return {7'h00, seq_busy};
      6: return {7'h00, seq_done};
      default: return {7'h00, timing_ok};
    endcase
  endfunction

  task automatic check(string what, logic [7:0] got, logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic note(int i, logic [7:0] v);
    notes.push_back('{i, v});
  endtask

  task automatic observe;
    -> sample_ev;
    #1;
  endtask

  // Counts falling edges until the masked output matches, failing past the limit.
  task automatic wait_for(int i, logic [7:0] m, logic [7:0] v, int lim, output int k);
    k = 0;
    while ((seen(i) & m) !== v && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= lim) begin
      check(nm[i], seen(i) & m, v);
    end
  endtask

  task automatic write_reg(int i, logic [7:0] d);
    @(negedge ref_clk);
    clock_control_wr = (i == 0);
    synth_control_wr = (i == 1);
    timer_mode_wr = (i == 2);
    usb_control_wr = (i == 3);
    {clock_control_wdata, synth_control_wdata, timer_mode_wdata, usb_control_wdata} = {4{d}};
    @(negedge ref_clk);
    {clock_control_wr, synth_control_wr, timer_mode_wr, usb_control_wr} = 4'h0;
  endtask

  task automatic do_reset;
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
  endtask

  task automatic pulse_start;
    @(negedge ref_clk);
    seq_start = 1'b1;
    @(negedge ref_clk);
    seq_start = 1'b0;
  endtask

  task finish_test;
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial forever begin
    @(sample_ev);
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      check(nm[cur.idx], seen(cur.idx), cur.val);
    end
  end

  initial begin
    #(90000 * 40);
    bad_count++;
    finish_test;
  end

  initial begin
    void'($urandom(32'h4a90));
    do_reset;
    note(0, 8'h80);
    note(1, 8'h60);
    note(3, 8'h00);
    note(4, 8'h00);
    observe;
    $display("test reset values done");
    pulse_start;
    wait_for(1, 8'h01, 8'h01, 5, n);
    repeat (SETTLE + 10) @(negedge ref_clk);
    note(1, 8'h61);
    note(4, 8'h00);
    note(3, 8'h00);
    note(5, 8'h01);
    observe;
    synth_lock = 1'b1;
    repeat (2) @(negedge ref_clk);
    note(4, 8'h01);
    observe;
    wait_for(1, 8'h60, 8'h40, 2600, n);
    timing_ok = (n >= 2400);
    note(7, 8'h01);
    observe;
    wait_for(3, 8'h18, 8'h10, 5, n);
    note(3, 8'h10);
    observe;
    wait_for(0, 8'h40, 8'h40, 25100, n);
    timing_ok = (n >= 25000);
    note(7, 8'h01);
    observe;
    wait_for(3, 8'h80, 8'h80, 20, n);
    timing_ok = (n >= 4);
    note(7, 8'h01);
    note(3, 8'h90);
    note(6, 8'h01);
    note(5, 8'h00);
    observe;
    $display("test bring-up with lock recheck done");
    r = 8'($urandom);
    write_reg(2, r);
    note(2, r);
    observe;
    @(negedge ref_clk);
    // The system clock is taken as already moved off the synthesizer.
    // Wait mode needs no such step; stop is driven here together with a timer mode write of ~r.
    stop_instruction = 1'b1;
    timer_mode_wr = 1'b1;
    timer_mode_wdata = ~r;
    @(negedge ref_clk);
    stop_instruction = 1'b0;
    timer_mode_wr = 1'b0;
    note(2, r & 8'h10);
    note(0, 8'h40);
    observe;
    write_reg(0, 8'hc0);
    write_reg(2, r);
    note(0, 8'hc0);
    note(2, r);
    observe;
    $display("test stop mode done");
    do_reset;
    note(0, 8'h80);
    note(2, 8'h00);
    note(3, 8'h00);
    note(6, 8'h00);
    observe;
    use_dcdc = 1'b0;
    cap_tenths_uf = 8'h01;
    // The multiply setup is taken as valid before each start.
    pulse_start;
    wait_for(3, 8'h80, 8'h80, 28000, n);
    note(3, 8'h80);
    note(1, 8'h41);
    observe;
    write_reg(3, 8'h88);
    write_reg(1, 8'h21);
    note(3, 8'h88);
    note(1, 8'h21);
    observe;
    $display("test low supply bring-up done");
    finish_test;
  end
endmodule // tb_usb_clock_bringup_sequencer
`default_nettype wire
